/* shared/uipc_pkg.sv */
package uipc_pkg;
    // Pipe response setting encodings
    localparam logic [1:0] RESP_NAK   = 2'h0;
    localparam logic [1:0] RESP_BUF   = 2'h1;
    localparam logic [1:0] RESP_STALL = 2'h2;
    // Data packet identifier codes (4-bit packet identifier field)
    localparam logic [3:0] PID_DATA0  = 4'h3;
    localparam logic [3:0] PID_DATA1  = 4'hB;
    localparam logic [3:0] PID_DATA2  = 4'h7;
    localparam logic [3:0] PID_MDATA  = 4'hF;
    // Interval exponent width and counter width
    localparam int          EXP_W     = 3;
    localparam logic [2:0]  EXP_RST   = 3'h0;
    localparam int          CNT_W     = 8;
    localparam logic [7:0]  CNT_ZERO  = 8'h00;
    localparam logic [7:0]  CNT_ONE   = 8'h01;
    // Packet size width and buffer parameters
    localparam int          SIZE_W    = 11;
    localparam int          DATA_W    = 8;
    localparam int          BUF_DEPTH = 2;
    // Counter state machine
    typedef enum logic [1:0] {
        UIPC_IDLE  = 2'h0,
        UIPC_ARMED = 2'h1,
        UIPC_RUN   = 2'h3
    } uipc_state_t;
endpackage : uipc_pkg

/* hw/uipc_iso_pipe.sv */
`timescale 1ns/1ns
module uipc_iso_pipe (
    input  wire logic                        clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        controller_enable_i,
    input  wire logic                        sleep_return_i,
    input  wire logic                        host_mode_i,
    input  wire logic                        high_speed_i,
    input  wire logic                        dir_in_i,
    input  wire logic                        suspend_i,
    input  wire logic                        bus_reset_i,
    input  wire logic                        buffer_auto_clear_i,
    input  wire logic                        exp_we_i,
    input  wire logic [uipc_pkg::EXP_W-1:0]  exp_wdata_i,
    input  wire logic [1:0]                  resp_wdata_i,
    input  wire logic                        resp_we_i,
    input  wire logic [uipc_pkg::SIZE_W-1:0] max_packet_size_i,
    input  wire logic                        sof_i,
    input  wire logic                        sof_interp_i,
    input  wire logic                        token_i,
    input  wire logic                        token_pid_ok_i,
    input  wire logic                        token_is_in_i,
    input  wire logic                        buf_empty_i,
    input  wire logic                        buf_has_data_i,
    input  wire logic                        pkt_start_i,
    input  wire logic [3:0]                  pkt_pid_i,
    input  wire logic                        pkt_pid_ok_i,
    input  wire logic                        pkt_crc_err_i,
    input  wire logic [uipc_pkg::SIZE_W-1:0] pkt_size_i,
    input  wire logic                        in_sent_i,
    input  wire logic                        rx_valid_i,
    output logic                             rx_ready_o,
    input  wire logic [uipc_pkg::DATA_W-1:0] rx_data_i,
    input  wire logic                        rx_last_i,
    output logic                             out_valid_o,
    input  wire logic                        out_ready_i,
    output logic [uipc_pkg::DATA_W-1:0]      out_data_o,
    output logic                             out_last_o,
    output logic [uipc_pkg::EXP_W-1:0]       interval_exponent_o,
    output logic [1:0]                       pipe_response_setting_o,
    output logic                             overrun_flag_o,
    output logic                             crc_error_flag_o,
    output logic                             not_ready_interrupt_o,
    output logic                             buffer_empty_interrupt_o,
    output logic                             send_zlp_o,
    output logic                             discard_out_o,
    output logic                             host_token_go_o,
    output logic                             flush_in_o,
    output logic                             token_missed_o,
    output logic [3:0]                       tx_pid_o,
    output logic                             interval_expired_o
);
    // Overview of the pipe logic:
    // - Token checks run in priority order:
    //   bad identifier, then overrun or
    //   underrun, then stray-OUT interval error.
    // - Packet checks run in priority order:
    //   bad identifier, CRC or stuffing,
    //   then oversize.
    // - One interval counter paces the pipe.
    //   It ticks on real and interpolated
    //   SOFs, so a damaged SOF does not
    //   shift the schedule.
    // - A two-entry buffer carries received
    //   words to the sink; words of a
    //   rejected packet are drained.
    // Event outputs are one-cycle pulses that
    // follow their cause combinationally, so
    // the caller samples them in that cycle.
    // Registered state moves on the next edge.
    // Limitation: one pipe only; a controller
    // with several pipes repeats this block.
    // Trade-off: the soft-reset group is
    // decoded once and shared, so a sleep
    // return acts like a hardware reset.

    // Soft reset covers hardware reset, enable drop and sleep return
    wire soft_rst = !rst_n_i || !controller_enable_i || sleep_return_i;

    logic [uipc_pkg::EXP_W-1:0] exponent;
    logic [1:0]                 resp;
    logic [uipc_pkg::CNT_W-1:0] count;
    uipc_pkg::uipc_state_t      state;
    uipc_pkg::uipc_state_t      next_state;
    logic                       good_xfer;
    logic                       seen_in_frame;
    logic                       acl_q;
    logic                       pkt_open;

    // Period decode as a function, used by the expiry compare
    function automatic logic [uipc_pkg::CNT_W-1:0] period_of(
        input logic [uipc_pkg::EXP_W-1:0] e);
        period_of = uipc_pkg::CNT_ONE << e;
    endfunction : period_of

    wire frame_tick = sof_i || sof_interp_i;
    wire resp_buf   = (resp == uipc_pkg::RESP_BUF);
    wire link_hold  = suspend_i || bus_reset_i;
    wire count_en   = frame_tick && resp_buf && !link_hold
                      && !buffer_auto_clear_i
                      && (state == uipc_pkg::UIPC_RUN);
    wire [uipc_pkg::CNT_W-1:0] period = period_of(exponent);
    // Compare with >= so a lowered exponent
    // mid-count ends the interval at once
    // instead of running the counter round.
    wire at_end     = (count >= period - uipc_pkg::CNT_ONE);
    wire expire     = count_en && at_end;

    // Token-time classification in priority order.
    // A token with a bad identifier is dropped
    // before any other test, so it can never
    // raise an interrupt. Overrun and underrun
    // come next; a stray-OUT interval error is only
    // reported when no run error is present; a missed IN is not gated.
    // Host checks are taken at interval expiry,
    // since the host owns the token schedule.
    wire tok_valid  = token_i && token_pid_ok_i;
    wire tok_ovr    = tok_valid && !host_mode_i &&
                      !token_is_in_i && !buf_empty_i;
    wire tok_und    = tok_valid && !host_mode_i &&
                      token_is_in_i && !buf_has_data_i;
    wire host_due   = expire && host_mode_i;
    wire host_ovr   = host_due && resp_buf && dir_in_i
                      && !buf_empty_i;
    wire host_und   = host_due && resp_buf && !dir_in_i
                      && !buf_has_data_i;
    wire run_err    = tok_ovr || tok_und || host_ovr || host_und;
    // Stray OUT outside the interval frame (already seen one)
    wire ivl_out    = tok_valid && !host_mode_i && !token_is_in_i
                      && !run_err && seen_in_frame
                      && (state == uipc_pkg::UIPC_RUN);
    wire miss_tok   = expire && !host_mode_i && !seen_in_frame;
    wire ivl_in     = miss_tok && dir_in_i;
    wire ivl_err    = (ivl_out || ivl_in) && !host_mode_i;

    // Data packet classification in priority order.
    // An unaccepted identifier counts as bad:
    // DATA2 and MDATA only pass at high speed.
    // CRC errors shadow the size test, so an
    // oversize packet with a CRC error gives
    // only the not-ready, CRC and discard events, never a stall.
    wire pid_data   = (pkt_pid_i == uipc_pkg::PID_DATA0) ||
                      (pkt_pid_i == uipc_pkg::PID_DATA1);
    wire pid_hs     = (pkt_pid_i == uipc_pkg::PID_DATA2) ||
                      (pkt_pid_i == uipc_pkg::PID_MDATA);
    wire pid_accept = pid_data || (high_speed_i && pid_hs);
    wire pkt_valid  = pkt_start_i && pkt_pid_ok_i && pid_accept;
    wire pkt_crc    = pkt_valid && pkt_crc_err_i;
    wire pkt_big    = pkt_valid && !pkt_crc_err_i &&
                      (pkt_size_i > max_packet_size_i);
    wire pkt_good   = pkt_valid && !pkt_crc_err_i && !pkt_big;

    // Successful buffered transfer arms the counter start
    wire xfer_ok    = resp_buf && ((in_sent_i && !host_mode_i) ||
                      pkt_good);

    // Interrupt and status pulses; at most one transaction per frame
    assign not_ready_interrupt_o   = run_err || ivl_err || pkt_crc;
    assign overrun_flag_o          = run_err;
    assign crc_error_flag_o        = pkt_crc;
    assign buffer_empty_interrupt_o = pkt_big;
    assign send_zlp_o    = tok_und;
    assign discard_out_o = tok_ovr || (pkt_start_i && !pkt_good);
    assign host_token_go_o = host_due && resp_buf
                             && !host_ovr && !host_und;
    assign flush_in_o    = miss_tok && dir_in_i;
    assign token_missed_o = miss_tok && !dir_in_i;
    assign tx_pid_o      = uipc_pkg::PID_DATA0;
    assign interval_expired_o = expire;
    assign interval_exponent_o = exponent;
    assign pipe_response_setting_o = resp;

    // Exponent field cleared only by the soft-reset group.
    // Auto-clear leaves it alone, so software
    // need not rewrite it after a buffer clear.
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            exponent <= uipc_pkg::EXP_RST;
        end else if (exp_we_i) begin
            exponent <= exp_wdata_i;
        end
    end

    // Oversize stall wins over a software write in the same cycle.
    // Hazard: letting the write win would
    // reopen a pipe that just saw a packet
    // larger than its buffer allows.
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            resp <= uipc_pkg::RESP_NAK;
        end else if (pkt_big) begin
            resp <= uipc_pkg::RESP_STALL;
        end else if (resp_we_i) begin
            resp <= resp_wdata_i;
        end
    end

    // Counter start state: armed by transfer, running after next SOF.
    // A peripheral waits for a good buffered
    // transfer so the interval lines up with
    // the host's schedule. A host owns the
    // schedule and runs from the start.
    // Suspend or bus reset also block the
    // arming SOF, matching the count hold.
    always_comb begin
        next_state = state;
        unique case (state)
            uipc_pkg::UIPC_IDLE: begin
                if (host_mode_i || xfer_ok) begin
                    next_state = host_mode_i ? uipc_pkg::UIPC_RUN
                                             : uipc_pkg::UIPC_ARMED;
                end
            end
            uipc_pkg::UIPC_ARMED: begin
                if (frame_tick && !link_hold) begin
                    next_state = uipc_pkg::UIPC_RUN;
                end
            end
            uipc_pkg::UIPC_RUN: begin
                next_state = state;
            end
            default: begin
                next_state = uipc_pkg::UIPC_IDLE;
            end
        endcase
    end

    // Auto-clear edge: start state returns to idle and waits to be armed again
    always_ff @(posedge clk_i) begin
        if (soft_rst || buffer_auto_clear_i) begin
            state <= uipc_pkg::UIPC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Interval counter; held through pause, suspend and bus reset.
    // NAK or STALL only pauses the count;
    // it resumes from where it stood.
    // Auto-clear zeroes it, and counting
    // restarts once the pipe is armed and running again.
    always_ff @(posedge clk_i) begin
        if (soft_rst || buffer_auto_clear_i) begin
            count <= uipc_pkg::CNT_ZERO;
        end else if (count_en) begin
            count <= at_end ? uipc_pkg::CNT_ZERO
                            : count + uipc_pkg::CNT_ONE;
        end
    end

    // Token seen in the current interval frame; a new token wins.
    // One flag per frame: a second OUT in the
    // same frame is a stray token, as only one
    // transaction per frame is served.
    always_ff @(posedge clk_i) begin
        if (soft_rst || buffer_auto_clear_i) begin
            seen_in_frame <= 1'b0;
        end else if (tok_valid && !run_err) begin
            seen_in_frame <= 1'b1;
        end else if (expire) begin
            seen_in_frame <= 1'b0;
        end
    end

    // Data of a rejected packet is dropped until its last word
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            pkt_open <= 1'b0;
            acl_q    <= 1'b0;
        end else begin
            acl_q <= buffer_auto_clear_i;
            if (pkt_start_i) begin
                pkt_open <= pkt_good;
            end else if (rx_valid_i && rx_ready_o && rx_last_i) begin
                pkt_open <= 1'b0;
            end
        end
    end

    // Two-entry skid buffer so a stalled sink loses no word.
    // Each entry holds a byte and its last
    // flag. Ready is combinational on the
    // fill level; data leaves from storage.
    // Limitation: two entries only, so a sink
    // stalled for long stalls the source.
    logic [uipc_pkg::DATA_W:0] mem [uipc_pkg::BUF_DEPTH];
    // Fill levels of the two-entry buffer
    localparam logic [1:0] FILL_EMPTY = 2'h0;
    localparam logic [1:0] FILL_FULL  = 2'h2;
    logic                      wr_ptr;
    logic                      rd_ptr;
    logic [1:0]                fill;
    wire fifo_full  = (fill == FILL_FULL);
    wire fifo_empty = (fill == FILL_EMPTY);
    wire push       = rx_valid_i && rx_ready_o && pkt_open;
    wire pop        = out_valid_o && out_ready_i;
    // Discarded words still drain so the source never hangs
    assign rx_ready_o  = !fifo_full || !pkt_open;
    assign out_valid_o = !fifo_empty;
    assign out_data_o  = mem[rd_ptr][uipc_pkg::DATA_W-1:0];
    assign out_last_o  = mem[rd_ptr][uipc_pkg::DATA_W];

    // Buffer storage and pointers.
    // Cleared one cycle after auto-clear rises,
    // so a word accepted in that cycle is
    // dropped with the rest of the buffer.
    always_ff @(posedge clk_i) begin
        if (soft_rst || acl_q) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            fill   <= FILL_EMPTY;
            mem[0] <= '0;
            mem[1] <= '0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= {rx_last_i, rx_data_i};
                wr_ptr      <= !wr_ptr;
            end
            if (pop) begin
                rd_ptr <= !rd_ptr;
            end
            fill <= fill + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : uipc_iso_pipe

/* testbench/uipc_iso_pipe_properties.sv */
`timescale 1ns/1ns
module uipc_iso_pipe_properties (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        controller_enable_i,
    input wire logic        host_mode_i,
    input wire logic        dir_in_i,
    input wire logic [10:0] max_packet_size_i,
    input wire logic        sof_i,
    input wire logic        sof_interp_i,
    input wire logic        token_i,
    input wire logic        token_pid_ok_i,
    input wire logic        token_is_in_i,
    input wire logic        buf_empty_i,
    input wire logic        buf_has_data_i,
    input wire logic        pkt_start_i,
    input wire logic [3:0]  pkt_pid_i,
    input wire logic        pkt_pid_ok_i,
    input wire logic        pkt_crc_err_i,
    input wire logic [10:0] pkt_size_i,
    input wire logic [2:0]  interval_exponent_o,
    input wire logic [1:0]  pipe_response_setting_o,
    input wire logic        overrun_flag_o,
    input wire logic        crc_error_flag_o,
    input wire logic        not_ready_interrupt_o,
    input wire logic        buffer_empty_interrupt_o,
    input wire logic        send_zlp_o,
    input wire logic        discard_out_o,
    input wire logic        host_token_go_o,
    input wire logic [3:0]  tx_pid_o
);
    default clocking dflt @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic tok;
    logic pkt;
    // Valid peripheral token on a pipe that is open for traffic
    assign tok = token_i && token_pid_ok_i && controller_enable_i
        && !host_mode_i && token_is_in_i == dir_in_i
        && pipe_response_setting_o == uipc_pkg::RESP_BUF;
    // DATA0 packet with a good identifier, accepted at any speed
    assign pkt = pkt_start_i && pkt_pid_ok_i && controller_enable_i
        && pkt_pid_i == uipc_pkg::PID_DATA0;
    AST_TX_DATA0: assert property (tx_pid_o == uipc_pkg::PID_DATA0)
        else $error("tx pid not DATA0");
    AST_BAD_TOKEN_QUIET: assert property (token_i && !token_pid_ok_i
        && !pkt_start_i && !sof_i && !sof_interp_i
        |-> !not_ready_interrupt_o && !overrun_flag_o)
        else $error("bad token raised an event");
    AST_OUT_OVERRUN: assert property (tok && !token_is_in_i && !buf_empty_i
        |-> overrun_flag_o && not_ready_interrupt_o && discard_out_o)
        else $error("out overrun not flagged");
    AST_IN_UNDERRUN: assert property (tok && token_is_in_i && !buf_has_data_i
        |-> overrun_flag_o && not_ready_interrupt_o && send_zlp_o)
        else $error("in underrun not flagged");
    AST_PKT_BAD_PID: assert property (pkt_start_i && !pkt_pid_ok_i
        |-> !crc_error_flag_o && !buffer_empty_interrupt_o)
        else $error("bad packet raised an event");
    AST_PKT_CRC: assert property (pkt && pkt_crc_err_i
        |-> crc_error_flag_o && not_ready_interrupt_o)
        else $error("crc error not flagged");
    AST_OVERSIZE: assert property (pkt && !pkt_crc_err_i
        && pkt_size_i > max_packet_size_i |-> buffer_empty_interrupt_o
        ##1 pipe_response_setting_o == uipc_pkg::RESP_STALL)
        else $error("oversize packet not stalled");
    AST_HOST_SKIP: assert property (host_mode_i
        && pipe_response_setting_o != uipc_pkg::RESP_BUF |-> !host_token_go_o)
        else $error("host token sent while not buffered");
    AST_SOFT_RESET_EXP: assert property (!controller_enable_i
        |=> interval_exponent_o == uipc_pkg::EXP_RST)
        else $error("exponent survived soft reset");
endmodule : uipc_iso_pipe_properties

bind uipc_iso_pipe uipc_iso_pipe_properties u_props (.*);

/* testbench/uipc_peer.sv */
`timescale 1ns/1ns
module uipc_peer (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic       rx_ready_i,
    output logic            rx_valid_o,
    output logic [7:0]      rx_data_o,
    output logic            rx_last_o,
    output logic            out_ready_o
);
    logic [3:0] left = 4'h0;
    logic [7:0] lfsr = 8'h5A;
    // Four-byte packet; a word moves only when accepted
    always_ff @(posedge clk_i) begin
        lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5]};
        if (go_i) left <= 4'h4;
        else if (rx_valid_o && rx_ready_i) left <= left - 4'h1;
    end
    // Idle data scrambles so stale bytes never look valid
    assign rx_valid_o  = left != 4'h0;
    assign rx_data_o   = rx_valid_o ? {4'hA, left} : ~lfsr;
    assign rx_last_o   = left == 4'h1;
    assign out_ready_o = lfsr[0]; // Random sink stalls
endmodule : uipc_peer

/* testbench/testbench.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    error_cnt++; $display("unexpected t=%0t %0h %0h", $time, g, e); end end
module testbench;
    logic clk_i, rst_n_i, controller_enable_i, sleep_return_i, host_mode_i;
    logic high_speed_i, dir_in_i, suspend_i, bus_reset_i, buffer_auto_clear_i;
    logic exp_we_i, resp_we_i, sof_i, sof_interp_i, token_i, token_pid_ok_i;
    logic token_is_in_i, buf_empty_i, buf_has_data_i, pkt_start_i, go;
    logic pkt_pid_ok_i, pkt_crc_err_i, in_sent_i, rx_valid_i, rx_last_i;
    logic out_ready_i, rx_ready_o, out_valid_o, out_last_o, overrun_flag_o;
    logic crc_error_flag_o, not_ready_interrupt_o, buffer_empty_interrupt_o;
    logic send_zlp_o, discard_out_o, host_token_go_o, flush_in_o, ex, fl;
    logic token_missed_o, interval_expired_o, tm, hg, ov;
    logic [2:0]  exp_wdata_i, interval_exponent_o;
    logic [1:0]  resp_wdata_i, pipe_response_setting_o;
    logic [3:0]  pkt_pid_i, tx_pid_o;
    logic [10:0] max_packet_size_i, pkt_size_i;
    logic [7:0]  rx_data_i, out_data_o;
    logic [15:0] seed;
    int error_cnt = 0, samples_checked = 0, words, last, gap, hits, e;
    int exps [4] = '{0, 1, 3, 7};
    logic [3:0] pids [4] = '{4'h3, 4'hB, 4'h7, 4'hF};
    uipc_iso_pipe u_dut (.*);
    uipc_peer u_peer (.clk_i(clk_i), .go_i(go), .rx_ready_i(rx_ready_o),
        .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
        .rx_last_o(rx_last_i), .out_ready_o(out_ready_i));
    always #5 clk_i = ~clk_i;
    function automatic logic [15:0] xs(input logic [15:0] s);
        s = s ^ (s << 7);
        s = s ^ (s >> 9);
        return s ^ (s << 8);
    endfunction : xs
    // Full speed takes DATA0 and DATA1 only; high speed takes all
    function automatic int accepted(input logic [3:0] p, input logic hs);
        return (hs || p == uipc_pkg::PID_DATA0 || p == uipc_pkg::PID_DATA1)
            ? 4 : 0;
    endfunction : accepted
    task automatic pulse(ref logic s);
        @(negedge clk_i) s = 1'b1;
        @(negedge clk_i) s = 1'b0;
    endtask : pulse
    task automatic cfg(input logic [2:0] x, input logic [1:0] r);
        @(negedge clk_i) {exp_wdata_i, resp_wdata_i, exp_we_i, resp_we_i} =
            {x, r, 2'h3};
        @(negedge clk_i) {exp_we_i, resp_we_i} = 2'h0;
    endtask : cfg
    // Frame tick, real or interpolated at random
    task automatic tick();
        seed = xs(seed);
        @(negedge clk_i) {sof_i, sof_interp_i} = {seed[0], ~seed[0]};
        #2 {ex, fl, tm, hg, ov} = {interval_expired_o, flush_in_o,
            token_missed_o, host_token_go_o, overrun_flag_o};
        hits += ex;
        @(negedge clk_i) {sof_i, sof_interp_i} = 2'h0;
    endtask : tick
    // Packet header, then count words handed on while the sink stalls
    task automatic pkt(input logic [3:0] p, input logic [10:0] z,
                       input logic c);
        @(negedge clk_i) {pkt_pid_i, pkt_size_i, pkt_crc_err_i} = {p, z, c};
        {pkt_start_i, pkt_pid_ok_i, go} = {1'b1, {2{p[1:0] == 2'h3}}};
        @(negedge clk_i) {pkt_start_i, go, words} = '0;
        repeat (30) @(negedge clk_i) if (out_valid_o && out_ready_i) begin
            `CHK(out_data_o, 8'hA4 - 8'(words))
            `CHK(out_last_o, words == 3)
            words++;
        end
    endtask : pkt
    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        {clk_i, rst_n_i, sleep_return_i, host_mode_i, high_speed_i, suspend_i,
         bus_reset_i, buffer_auto_clear_i, exp_we_i, resp_we_i, sof_i, go,
         sof_interp_i, token_i, token_pid_ok_i, token_is_in_i, buf_has_data_i,
         pkt_start_i, pkt_pid_ok_i, pkt_crc_err_i, in_sent_i} = '0;
        {controller_enable_i, dir_in_i, buf_empty_i} = 3'h7;
        {exp_wdata_i, resp_wdata_i, pkt_pid_i, pkt_size_i} = '0;
        {max_packet_size_i, seed} = {11'h040, 16'h775E};
        repeat (2) @(negedge clk_i);
        rst_n_i = 1'b1;
        `CHK(interval_exponent_o, uipc_pkg::EXP_RST)
        `CHK(pipe_response_setting_o, uipc_pkg::RESP_NAK)
        `CHK(tx_pid_o, uipc_pkg::PID_DATA0)
        for (int k = 0; k < 4; k++) begin
            e = exps[k];
            pulse(buffer_auto_clear_i);
            if (k > 0) `CHK(interval_exponent_o, 3'(exps[k - 1]))
            cfg(3'(e), uipc_pkg::RESP_BUF);
            pulse(in_sent_i);
            {last, gap} = {-32'sd1, 32'sd0};
            for (int i = 0; i < 3 * (1 << e) + 2; i++) begin
                tick();
                `CHK(fl, ex)
                if (ex && last >= 0) gap = i - last;
                if (ex) last = i;
            end
            `CHK(gap, 1 << e)
        end
        // Pause by NAK, then hold by suspend, then resume
        pulse(buffer_auto_clear_i);
        cfg(3'h1, uipc_pkg::RESP_BUF);
        pulse(in_sent_i);
        repeat (2) tick();
        cfg(3'h1, uipc_pkg::RESP_NAK);
        hits = 0;
        repeat (4) tick();
        cfg(3'h1, uipc_pkg::RESP_BUF);
        suspend_i = 1'b1;
        repeat (4) tick();
        `CHK(hits, 0)
        suspend_i = 1'b0;
        tick();
        `CHK(hits, 1)
        repeat (24) begin
            seed = xs(seed);
            cfg(3'h0, seed[6] ? uipc_pkg::RESP_BUF : uipc_pkg::RESP_NAK);
            @(negedge clk_i) {token_pid_ok_i, token_is_in_i, buf_empty_i,
                buf_has_data_i, host_mode_i, dir_in_i, token_i} =
                {seed[5:0], 1'b1};
            @(negedge clk_i) token_i = 1'b0;
        end
        {host_mode_i, dir_in_i, buf_empty_i} = 3'h1;
        cfg(3'h5, uipc_pkg::RESP_BUF);
        for (int k = 0; k < 8; k++) begin
            high_speed_i = k[2];
            pkt(pids[k % 4], 11'h040, 1'b0);
            `CHK(words, accepted(pids[k % 4], k[2]))
        end
        pkt(4'h5, 11'h004, 1'b0);
        `CHK(words, 0)
        pkt(uipc_pkg::PID_DATA0, 11'h004, 1'b1);
        `CHK(words, 0)
        pkt(uipc_pkg::PID_DATA0, 11'h041, 1'b0);
        `CHK(pipe_response_setting_o, uipc_pkg::RESP_STALL)
        @(negedge clk_i) controller_enable_i = 1'b0;
        @(negedge clk_i) controller_enable_i = 1'b1;
        `CHK(interval_exponent_o, uipc_pkg::EXP_RST)
        cfg(3'h2, uipc_pkg::RESP_BUF);
        pulse(sleep_return_i);
        `CHK(interval_exponent_o, uipc_pkg::EXP_RST)
        `CHK(pipe_response_setting_o, uipc_pkg::RESP_NAK)
        // Missed OUT token, then a served one
        {dir_in_i, buf_empty_i, token_pid_ok_i, token_is_in_i} = 4'h6;
        cfg(3'h0, uipc_pkg::RESP_BUF);
        pulse(in_sent_i);
        repeat (2) tick();
        `CHK(tm, 1'b1)
        pulse(token_i);
        tick();
        `CHK(tm, 1'b0)
        // Host: token goes when empty, overrun when not
        {host_mode_i, dir_in_i} = 2'h3;
        tick();
        `CHK(hg, 1'b1)
        buf_empty_i = 1'b0;
        tick();
        `CHK(ov, 1'b1)
        `CHK(hg, 1'b0)
        print_verdict();
    end
    // Hang guard
    initial begin
        #900000;
        error_cnt++;
        print_verdict();
    end
endmodule : testbench
